// ==== pkg/pas_pkg.sv ====
// package: register map, field layout and reset values of the auto-shutdown block
package pas_pkg;
    // ----------------------------------------
    // register map (word addresses are byte offsets)
    // ----------------------------------------
    localparam logic [3:0] PAS_OFF_CTRL = 4'h0;
    localparam logic [3:0] PAS_OFF_IRQ_STAT = 4'h4;
    localparam logic [3:0] PAS_OFF_IRQ_MASK = 4'h8;
    localparam logic [3:0] PAS_OFF_PWM_IN = 4'hc;
    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int PAS_BIT_FLAG = 7;
    localparam int PAS_SRC_LSB = 4;
    localparam int PAS_STA_LSB = 2;
    localparam int PAS_STB_LSB = 0;
    localparam logic [7:0] PAS_CTRL_RST = 8'h00;
    localparam logic [1:0] PAS_IRQ_RST = 2'h0;
    // irq status bits
    localparam int PAS_IRQ_SHUT = 0;
    localparam int PAS_IRQ_REL = 1;
    // ----------------------------------------
    // source select codes
    // ----------------------------------------
    localparam logic [2:0] PAS_SRC_OFF = 3'h0;
    localparam logic [2:0] PAS_SRC_CMP = 3'h1;
    localparam logic [2:0] PAS_SRC_CMP2 = 3'h3;
    localparam logic [2:0] PAS_SRC_PIN = 3'h4;
    localparam logic [2:0] PAS_SRC_ANY = 3'h5;
    localparam logic [2:0] PAS_SRC_ANY2 = 3'h7;
    // ----------------------------------------
    // shutdown pin state codes
    // ----------------------------------------
    localparam logic [1:0] PAS_ST_LOW = 2'h0;
    localparam logic [1:0] PAS_ST_HIGH = 2'h1;
endpackage

// ==== src/pas_pin_drive.sv ====
// one pwm pin: normal pass-through or programmed shutdown state
`timescale 1ns/1ps
module pas_pin_drive
    import pas_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pwm_in,
    input wire logic shut,
    input wire logic [1:0] state_sel,
    output logic pin_o,
    output logic pin_oe
);
    typedef struct packed {
        logic o;
        logic oe;
    } pas_pin_type;

    pas_pin_type pin_ff;
    pas_pin_type nxt_pin;

    always_comb begin
        nxt_pin.o = pwm_in;
        nxt_pin.oe = 1'b1;
        if (shut) begin
            // upper bit set releases the pin
            nxt_pin.oe = ~state_sel[1];
            nxt_pin.o = (state_sel == PAS_ST_HIGH);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_ff <= '0;
        end else begin
            pin_ff <= nxt_pin;
        end
    end

    assign pin_o = pin_ff.o;
    assign pin_oe = pin_ff.oe;
endmodule

// ==== src/pas_top.sv ====
// auto-shutdown control for a two-output pwm unit, wishbone register access
// ----------------------------------------
// How it works
// - selected event sets flag; both outputs held in shutdown states while set
// - source field picks fault pin low, comparator low, or either; 110/010 reserved
// - source code 000 triggers nothing; a flag already set still holds the outputs until software clears it
// - output A shutdown state: 1x tri-state, 01 high, 00 low
// - output B shutdown state: 1x tri-state, 01 high, 00 low
// ----------------------------------------
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module pas_top
    import pas_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic FAULT_INPUT_PIN,
    input wire logic COMPARATOR_OUT,
    input wire logic PWM_A_IN,
    input wire logic PWM_B_IN,
    output logic PWM_OUT_A_O,
    output logic PWM_OUT_A_OE,
    output logic PWM_OUT_B_O,
    output logic PWM_OUT_B_OE,
    output logic IRQ
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic flag;
        logic [2:0] src;
        logic [1:0] sta;
        logic [1:0] stb;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic ack;
        logic [31:0] dat;
        logic irq;
    } pas_state_type;

    pas_state_type st_ff;
    pas_state_type nxt_st;

    // decodes the selected fault condition for a source code
    function automatic logic fault_of(input logic [2:0] code, input logic pin_n,
                                      input logic cmp);
        logic pin_low;
        logic cmp_low;
        pin_low = ~pin_n;
        cmp_low = ~cmp;
        case (code)
            PAS_SRC_CMP, PAS_SRC_CMP2: fault_of = cmp_low;
            PAS_SRC_PIN: fault_of = pin_low;
            PAS_SRC_ANY, PAS_SRC_ANY2: fault_of = pin_low | cmp_low;
            default: fault_of = 1'b0; // off and reserved codes never trigger
        endcase
    endfunction

    logic fault;
    logic req;
    logic wr;
    logic ctrl_wr;
    logic [31:0] rd;

    assign fault = fault_of(st_ff.src, FAULT_INPUT_PIN, COMPARATOR_OUT);
    assign req = WB_CYC_I & WB_STB_I & ~st_ff.ack;
    assign wr = req & WB_WE_I;
    assign ctrl_wr = wr & (WB_ADR_I == PAS_OFF_CTRL) & WB_SEL_I[0];

    always_comb begin
        rd = 32'h0000_0000;
        case (WB_ADR_I)
            PAS_OFF_CTRL: rd = {24'h000000, st_ff.flag, st_ff.src, st_ff.sta, st_ff.stb};
            PAS_OFF_IRQ_STAT: rd = {30'h0, st_ff.irq_stat};
            PAS_OFF_IRQ_MASK: rd = {30'h0, st_ff.irq_mask};
            PAS_OFF_PWM_IN: rd = {30'h0, PWM_A_IN, PWM_B_IN};
            default: rd = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req;
        nxt_st.dat = req ? rd : 32'h0000_0000;
        if (ctrl_wr) begin
            nxt_st.src = WB_DAT_I[PAS_SRC_LSB +: 3];
            nxt_st.sta = WB_DAT_I[PAS_STA_LSB +: 2];
            nxt_st.stb = WB_DAT_I[PAS_STB_LSB +: 2];
            // software may clear only; the flag is not set by a write
            if (!WB_DAT_I[PAS_BIT_FLAG] && !fault) begin
                nxt_st.flag = 1'b0;
            end
        end
        if (wr && WB_ADR_I == PAS_OFF_IRQ_MASK && WB_SEL_I[0]) begin
            nxt_st.irq_mask = WB_DAT_I[1:0];
        end
        if (wr && WB_ADR_I == PAS_OFF_IRQ_STAT && WB_SEL_I[0]) begin
            nxt_st.irq_stat = st_ff.irq_stat & ~WB_DAT_I[1:0];
        end
        // a fault wins over a clear in the same cycle
        if (fault) begin
            nxt_st.flag = 1'b1;
        end
        if (fault && !st_ff.flag) begin
            nxt_st.irq_stat[PAS_IRQ_SHUT] = 1'b1;
        end
        if (st_ff.flag && !nxt_st.flag) begin
            nxt_st.irq_stat[PAS_IRQ_REL] = 1'b1;
        end
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // flag already registered, so the pins follow one cycle after it
    pas_pin_drive u_pin_a (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .pwm_in(PWM_A_IN),
        .shut(st_ff.flag),
        .state_sel(st_ff.sta),
        .pin_o(PWM_OUT_A_O),
        .pin_oe(PWM_OUT_A_OE)
    );

    pas_pin_drive u_pin_b (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .pwm_in(PWM_B_IN),
        .shut(st_ff.flag),
        .state_sel(st_ff.stb),
        .pin_o(PWM_OUT_B_O),
        .pin_oe(PWM_OUT_B_OE)
    );

    assign WB_ACK_O = st_ff.ack;
    assign WB_DAT_O = st_ff.dat;
    assign IRQ = st_ff.irq;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_fault_seen;
        fault;
    endsequence

    // pins register the flag and states one edge after they are seen
    sequence s_shut_pins;
        ##1 (PWM_OUT_A_OE == ~$past(st_ff.sta[1])) && (PWM_OUT_B_OE == ~$past(st_ff.stb[1]));
    endsequence

    property p_flag_set;
        @(posedge CORE_CLK) disable iff (SYS_RST) s_fault_seen |=> st_ff.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on fault");

    property p_pins_shut;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            s_fault_seen ##1 (st_ff.flag && $stable(st_ff.sta) && $stable(st_ff.stb))
            |-> s_shut_pins;
    endproperty
    a_pins_shut: assert property (p_pins_shut) else $error("pins not in shutdown");

    property p_pin_only;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            (st_ff.src == PAS_SRC_PIN && FAULT_INPUT_PIN) |-> !fault;
    endproperty
    a_pin_only: assert property (p_pin_only) else $error("pin source fired");

    property p_disabled;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            (st_ff.src == PAS_SRC_OFF && !st_ff.flag && !ctrl_wr) |=> !st_ff.flag;
    endproperty
    a_disabled: assert property (p_disabled) else $error("shutdown while disabled");

    property p_a_high;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            (st_ff.flag && st_ff.sta == PAS_ST_HIGH) |=> (PWM_OUT_A_O && PWM_OUT_A_OE);
    endproperty
    a_a_high: assert property (p_a_high) else $error("output A not high");

    property p_a_tri;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            (st_ff.flag && st_ff.sta[1]) |=> !PWM_OUT_A_OE;
    endproperty
    a_a_tri: assert property (p_a_tri) else $error("output A driven");

    property p_b_high;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            (st_ff.flag && st_ff.stb == PAS_ST_HIGH) |=> (PWM_OUT_B_O && PWM_OUT_B_OE);
    endproperty
    a_b_high: assert property (p_b_high) else $error("output B not high");

    property p_b_low;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            (st_ff.flag && st_ff.stb == PAS_ST_LOW) |=> (!PWM_OUT_B_O && PWM_OUT_B_OE);
    endproperty
    a_b_low: assert property (p_b_low) else $error("output B not low");

    property p_b_tri;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            (st_ff.flag && st_ff.stb[1]) |=> !PWM_OUT_B_OE;
    endproperty
    a_b_tri: assert property (p_b_tri) else $error("output B driven");

    property p_hold;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            (st_ff.flag && !ctrl_wr) |=> st_ff.flag;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped by itself");
endmodule

// ==== test/pas_fault_model.sv ====
// fault pin and comparator model for the auto-shutdown bench
`timescale 1ns/1ps
module pas_fault_model (
    input wire logic clk,
    input wire logic pin_fault,
    input wire logic cmp_fault,
    output logic FAULT_INPUT_PIN = 1'b1,
    output logic COMPARATOR_OUT = 1'b1
);
    // both sources are active low, so idle is high
    always @(posedge clk) begin
        FAULT_INPUT_PIN <= !pin_fault;
        COMPARATOR_OUT <= !cmp_fault;
    end
endmodule

// ==== test/pas_top_tb_top.sv ====
// self-checking bench for the auto-shutdown block
`timescale 1ns/1ps
module pas_top_tb_top;
    import pas_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic CORE_CLK = 0, SYS_RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
    logic [3:0] WB_ADR_I = 4'h0, WB_SEL_I = 4'hf;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, seed = 32'h00000e86;
    logic WB_ACK_O, PWM_A_IN = 0, PWM_B_IN = 0, pin_fault = 0, cmp_fault = 0;
    logic FAULT_INPUT_PIN, COMPARATOR_OUT, IRQ;
    logic PWM_OUT_A_O, PWM_OUT_A_OE, PWM_OUT_B_O, PWM_OUT_B_OE;
    logic [31:0] rd_q[$];
    int err_count = 0, total_checks = 0, cycles = 0;
    pas_top dut (.CORE_CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
        .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .FAULT_INPUT_PIN, .COMPARATOR_OUT,
        .PWM_A_IN, .PWM_B_IN, .PWM_OUT_A_O, .PWM_OUT_A_OE, .PWM_OUT_B_O,
        .PWM_OUT_B_OE, .IRQ);
    pas_fault_model fm (.clk(CORE_CLK), .pin_fault, .cmp_fault, .FAULT_INPUT_PIN,
        .COMPARATOR_OUT);
    initial forever #2.5 CORE_CLK = ~CORE_CLK;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // request held until the edge that samples ack, released after it
    // no local limit: a hung slave is caught by the cycle ceiling below
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge CORE_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_SEL_I <= 4'hf;
        WB_DAT_I <= dat;
        do begin
            @(posedge CORE_CLK);
        end while (WB_ACK_O !== 1'b1);
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, adr, 32'h0);
    endtask
    task automatic pins(input logic sh, input logic [3:0] st);
        check({PWM_OUT_A_OE, PWM_OUT_A_O}, sh ? {!st[3], !st[3] & st[2]} : {1'b1, PWM_A_IN});
        check({PWM_OUT_B_OE, PWM_OUT_B_O}, sh ? {!st[1], !st[1] & st[0]} : {1'b1, PWM_B_IN});
    endtask
    // ----------------------------------------
    // read monitor and timeout
    // ----------------------------------------
    always @(posedge CORE_CLK) begin
        cycles++;
        if (WB_ACK_O === 1'b1 && !WB_WE_I && rd_q.size() > 0)
            check(WB_DAT_O, rd_q.pop_front());
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [2:0] src;
        logic [3:0] st;
        logic sh;
        repeat (16) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        rd(PAS_OFF_CTRL, 32'h0);
        rd(PAS_OFF_IRQ_MASK, 32'h0);
        rd(4'h2, 32'h0);
        // every source code, once with pin fault and once with comparator fault
        for (int i = 0; i < 16; i++) begin
            src = 3'(i >> 1);
            st = 4'(rnd());
            sh = i[0] ? src[0] : src[2] & (src[0] | !src[1]);
            {PWM_A_IN, PWM_B_IN} <= 2'(rnd());
            wb(1'b1, PAS_OFF_IRQ_MASK, {31'h0, i[1]});
            wb(1'b1, PAS_OFF_IRQ_STAT, 32'h3);
            rd(PAS_OFF_PWM_IN, {30'h0, PWM_A_IN, PWM_B_IN});
            wb(1'b1, PAS_OFF_CTRL, {24'h0, 1'b0, src, st});
            cmp_fault <= i[0];
            pin_fault <= !i[0];
            repeat (4) @(posedge CORE_CLK);
            #1 pins(sh, st);
            check(IRQ, sh & i[1]);
            // clearing while the fault is present must not release
            wb(1'b1, PAS_OFF_CTRL, {24'h0, 1'b0, src, st});
            rd(PAS_OFF_CTRL, {24'h0, sh, src, st});
            rd(PAS_OFF_IRQ_STAT, {31'h0, sh});
            cmp_fault <= 1'b0;
            pin_fault <= 1'b0;
            repeat (3) @(posedge CORE_CLK);
            #1 pins(sh, st);
            wb(1'b1, PAS_OFF_CTRL, {24'h0, 1'b0, src, st});
            repeat (3) @(posedge CORE_CLK);
            #1 pins(1'b0, st);
            rd(PAS_OFF_CTRL, {24'h0, 1'b0, src, st});
            rd(PAS_OFF_IRQ_STAT, {30'h0, sh, sh});
        end
        finish_test();
    end
endmodule
